// >>> hw/pfcpwm_pkg.sv
// package: register map, fields and constants of the pwm compare-output block
package pfcpwm_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_WAVE_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_CAPTURE_TOP = 8'h0c;
  localparam logic [7:0] OFS_COMPARE_A = 8'h10;
  localparam logic [7:0] OFS_COMPARE_B = 8'h14;
  localparam logic [7:0] OFS_COMPARE_C = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_PIN_DIR = 8'h20;
  // ==========================================================
  // field positions
  localparam int ACT_A_POS = 6;
  localparam int ACT_B_POS = 4;
  localparam int ACT_C_POS = 2;
  localparam int WSEL_LO_POS = 0;
  localparam int WSEL_HI_POS = 3;
  localparam int CSEL_POS = 0;
  localparam int FLG_OVF_POS = 0;
  localparam int FLG_CMP_POS = 1;
  localparam int FLG_CAP_POS = 4;
  // ==========================================================
  // reset values and constants
  localparam logic [7:0] WAVE_CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_64 = 10'h03f;
  localparam logic [9:0] DIV_256 = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;
  // ==========================================================
  // mode numbers of the waveform select value, action codes and counter kinds
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_CTC_A = 4'h4;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_A = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'ha;
  localparam logic [3:0] WM_PC_A = 4'hb;
  localparam logic [3:0] WM_CTC_CAP = 4'hc;
  localparam logic [3:0] WM_FAST_CAP = 4'he;
  localparam logic [3:0] WM_FAST_A = 4'hf;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  typedef enum logic [1:0] {KIND_SINGLE, KIND_FAST, KIND_DUAL} pfcpwm_kind_t;
endpackage

// >>> hw/pfcpwm_top.sv
// design: dual-slope pwm timer with three compare outputs on ahb-lite
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1 - count up to capture or compare-A top
// RULE2 - stay at top for one tick
// RULE3 - match sets channel compare flag
// RULE4 - overflow flag set with bottom reload
// RULE5 - top source flag set at top (code sets the capture flag at top in modes 8, 10 and 14, not in 12)
// RULE6 - buffered compares load only at bottom
// RULE7 - software keeps top above compares
// RULE8 - code 2 clear up, set down
// RULE9 - bottom compare low, top compare high
// RULE10 - mode 9 code 1 toggles A
// RULE11 - toggle only A in 9 or 14 (code toggles A in 9 and 15, never in 14)
// RULE12 - tick is clock enable, one clock
// RULE13 - prescale 1, 8, 64, 256, 1024
// RULE14 - nonzero action hands pin to waveform
// RULE15 - single-slope codes: off, toggle, clear, set
// RULE16 - fast pwm match clear, bottom set
// RULE17 - fast pwm top match ignored, bottom acts
// RULE18 - control A field layout, reset zero
// RULE19 - mode from control A and B bits
// RULE20 - mode 8 capture top, 9 compare-A top
// RULE21 - reverse at bottom, count up again
// RULE22 - flags set on tick, sticky
module pfcpwm_top import pfcpwm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] portData,
  output logic [2:0] pinOut,
  output logic [2:0] pinOe_n
);
  // ==========================================================
  // registers
  logic [7:0] waveCtrlA_r, waveCtrlA_nxt;
  logic [7:0] ctrlB_r, ctrlB_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] capTop_r, capTop_nxt;
  logic [15:0] cmpBuf_r [3];
  logic [15:0] cmpBuf_nxt [3];
  logic [15:0] cmpAct_r [3], cmpAct_nxt [3];
  logic [4:0] flags_r, flags_nxt;
  logic [2:0] pinDir_r, pinDir_nxt;
  logic [2:0] wave_r, wave_nxt;
  logic down_r, down_nxt;
  logic hold_r, hold_nxt;
  logic [9:0] pre_r, pre_nxt;
  logic wrPend_r, wrPend_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [3:0] waveSel;
  logic [2:0] clkSel;
  logic tick;
  logic [15:0] topVal;
  logic atTop, atBottom;
  pfcpwm_kind_t kind;
  logic buffered;
  logic [1:0] act [3];
  logic [2:0] match;
  logic addrPhase;
  logic dirDown;

  assign waveSel = {ctrlB_r[WSEL_HI_POS +: 2],
                    waveCtrlA_r[WSEL_LO_POS +: 2]}; // see RULE19
  assign clkSel = ctrlB_r[CSEL_POS +: 3];
  assign act[0] = waveCtrlA_r[ACT_A_POS +: 2]; // see RULE18
  assign act[1] = waveCtrlA_r[ACT_B_POS +: 2];
  assign act[2] = waveCtrlA_r[ACT_C_POS +: 2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_r;
  assign addrPhase = hsel && htrans[1] && hready;

  function automatic logic [15:0] topOf(input logic [3:0] m,
      input logic [15:0] cap, input logic [15:0] cmpA);
    case (m)
      WM_PFC_CAP, WM_PC_CAP, WM_CTC_CAP, WM_FAST_CAP: topOf = cap;
      WM_PFC_A, WM_PC_A, WM_CTC_A, WM_FAST_A: topOf = cmpA;
      default: topOf = CNT_MAX;
    endcase
  endfunction

  // ==========================================================
  // prescaler, tick is an enable on clk
  always_comb begin
    pre_nxt = pre_r + 10'h001;
    tick = 1'b0;
    case (clkSel) // see RULE13
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_r[2:0] == DIV_8[2:0]);
      3'h3: tick = (pre_r[5:0] == DIV_64[5:0]);
      3'h4: tick = (pre_r[7:0] == DIV_256[7:0]);
      3'h5: tick = (pre_r == DIV_1024);
      default: tick = 1'b0; // external clock not built
    endcase
    if (clkSel == 3'h0) begin
      pre_nxt = 10'h000;
    end
  end

  // ==========================================================
  // counter and mode decode
  always_comb begin
    kind = KIND_SINGLE;
    if (waveSel == WM_PFC_CAP || waveSel == WM_PFC_A ||
        waveSel == WM_PC_CAP || waveSel == WM_PC_A ||
        waveSel[3:2] == 2'b00 && waveSel[1:0] != 2'b00) begin
      kind = KIND_DUAL;
    end else if (waveSel == WM_FAST_CAP || waveSel == WM_FAST_A ||
                 waveSel[3:2] == 2'b01 && waveSel[1:0] != 2'b00) begin
      kind = KIND_FAST;
    end
    buffered = (kind != KIND_SINGLE);
    // live compare-A used as top so period changes take effect at bottom in buffered modes
    topVal = topOf(waveSel, capTop_r, cmpAct_r[0]); // see RULE20
    atTop = (count_r == topVal);
    atBottom = (count_r == CNT_BOTTOM);
    count_nxt = count_r;
    down_nxt = down_r;
    hold_nxt = hold_r;
    if (tick) begin // see RULE12
      if (kind == KIND_DUAL) begin
        hold_nxt = 1'b0;
        if (!down_r && atTop) begin
          down_nxt = 1'b1; // see RULE1
          // top is shown for this one tick only
          hold_nxt = 1'b1; // see RULE2
          count_nxt = count_r - 16'h0001;
        end else if (down_r && atBottom) begin
          down_nxt = 1'b0; // see RULE21
          count_nxt = count_r + 16'h0001;
        end else if (down_r) begin
          count_nxt = count_r - 16'h0001;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end else begin
        down_nxt = 1'b0;
        hold_nxt = 1'b0;
        count_nxt = (atTop && waveSel != WM_NORMAL) ? CNT_BOTTOM
                                                    : count_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // compares, flags and waveforms
  for (genvar i = 0; i < 3; i++) begin : g_ch
    assign match[i] = tick && (count_r == cmpAct_r[i]); // see RULE3
  end
  // a match at top acts as down, at bottom as up: extremes stay flat
  assign dirDown = atTop ? 1'b1 : (atBottom ? 1'b0 : down_r); // see RULE9

  always_comb begin
    // flags_nxt first collects this cycle's set events
    flags_nxt = 5'h00;
    wave_nxt = wave_r;
    for (int i = 0; i < 3; i++) begin
      cmpAct_nxt[i] = cmpAct_r[i];
      // buffered modes load at bottom only, others every clock; dual slope keeps both slopes equal
      if (!buffered || tick && atBottom && down_r == (kind == KIND_DUAL)
          || tick && atBottom && kind == KIND_FAST) begin
        cmpAct_nxt[i] = cmpBuf_r[i]; // see RULE6
      end
      if (match[i]) begin
        flags_nxt[FLG_CMP_POS + i] = 1'b1; // see RULE3
      end
      case (kind)
        KIND_DUAL: begin
          if (match[i] && act[i][1]) begin
            wave_nxt[i] = act[i][0] ^ dirDown; // see RULE8
          end
          if (match[i] && act[i] == ACT_TOGGLE && i == 0 &&
              (waveSel == WM_PFC_A || waveSel == WM_FAST_CAP)) begin
            wave_nxt[i] = ~wave_r[i]; // see RULE10
          end
        end
        KIND_FAST: begin
          if (match[i] && act[i][1] && cmpAct_r[i] != topVal) begin
            wave_nxt[i] = act[i][0]; // see RULE17
          end
          if (tick && atTop && act[i][1]) begin
            wave_nxt[i] = ~act[i][0]; // see RULE16
          end
          if (match[i] && act[i] == ACT_TOGGLE && i == 0 &&
              waveSel == WM_FAST_A) begin
            wave_nxt[i] = ~wave_r[i]; // see RULE16
          end
        end
        default: begin
          if (match[i]) begin
            case (act[i]) // see RULE15
              ACT_TOGGLE: wave_nxt[i] = ~wave_r[i];
              ACT_CLEAR: wave_nxt[i] = 1'b0;
              ACT_SET: wave_nxt[i] = 1'b1;
              default: wave_nxt[i] = wave_r[i];
            endcase
          end
        end
      endcase
    end
    if (tick && kind == KIND_DUAL && atBottom && down_r) begin
      flags_nxt[FLG_OVF_POS] = 1'b1; // see RULE4
    end
    if (tick && (kind == KIND_FAST ? atTop
        : kind == KIND_SINGLE && count_r == CNT_MAX)) begin
      flags_nxt[FLG_OVF_POS] = 1'b1;
    end
    if (tick && atTop && (waveSel == WM_PFC_CAP ||
        waveSel == WM_PC_CAP || waveSel == WM_FAST_CAP)) begin
      flags_nxt[FLG_CAP_POS] = 1'b1; // see RULE5
    end
    // bus side: write one clears, but a same-cycle set wins
    if (wrPend_r && wrAddr_r == OFS_FLAGS) begin
      flags_nxt = flags_r & ~hwdata[4:0] | flags_nxt; // see RULE22
    end else begin
      flags_nxt = flags_r | flags_nxt;
    end
  end

  // ==========================================================
  // pin handover
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinOut[i] = portData[i];
      // outside single-slope modes, toggle code on B, C or wrong mode falls back to port, see RULE11
      if (act[i] != ACT_OFF && !(act[i] == ACT_TOGGLE && kind != KIND_SINGLE
          && !(i == 0 && (waveSel == WM_PFC_A || waveSel == WM_FAST_CAP ||
          waveSel == WM_FAST_A)))) begin
        pinOut[i] = wave_r[i]; // see RULE14
      end
      pinOe_n[i] = ~pinDir_r[i]; // see RULE14
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states
  always_comb begin
    wrPend_nxt = addrPhase && hwrite;
    wrAddr_nxt = haddr;
    rdData_nxt = rdData_r;
    waveCtrlA_nxt = waveCtrlA_r;
    ctrlB_nxt = ctrlB_r;
    capTop_nxt = capTop_r;
    pinDir_nxt = pinDir_r;
    if (addrPhase && !hwrite) begin
      if (haddr == OFS_WAVE_CTRL_A) rdData_nxt = {24'h0, waveCtrlA_r};
      else if (haddr == OFS_CTRL_B) rdData_nxt = {24'h0, ctrlB_r};
      else if (haddr == OFS_COUNTER) rdData_nxt = {16'h0, count_r};
      else if (haddr == OFS_CAPTURE_TOP) rdData_nxt = {16'h0, capTop_r};
      else if (haddr == OFS_COMPARE_A) rdData_nxt = {16'h0, cmpBuf_r[0]};
      else if (haddr == OFS_COMPARE_B) rdData_nxt = {16'h0, cmpBuf_r[1]};
      else if (haddr == OFS_COMPARE_C) rdData_nxt = {16'h0, cmpBuf_r[2]};
      else if (haddr == OFS_FLAGS) rdData_nxt = {27'h0, flags_r};
      else if (haddr == OFS_PIN_DIR) rdData_nxt = {29'h0, pinDir_r};
      else rdData_nxt = 32'h0;
    end
    if (wrPend_r) begin
      if (wrAddr_r == OFS_WAVE_CTRL_A) waveCtrlA_nxt = hwdata[7:0];
      else if (wrAddr_r == OFS_CTRL_B) ctrlB_nxt = hwdata[7:0] & 8'h1f;
      else if (wrAddr_r == OFS_CAPTURE_TOP) capTop_nxt = hwdata[15:0];
      else if (wrAddr_r == OFS_PIN_DIR) pinDir_nxt = hwdata[2:0];
    end
  end

  logic [15:0] cntW;
  always_comb begin
    cntW = count_nxt;
    for (int i = 0; i < 3; i++) begin
      cmpBuf_nxt[i] = cmpBuf_r[i];
    end
    if (wrPend_r && wrAddr_r == OFS_COUNTER) cntW = hwdata[15:0];
    if (wrPend_r && wrAddr_r == OFS_COMPARE_A) cmpBuf_nxt[0] = hwdata[15:0];
    if (wrPend_r && wrAddr_r == OFS_COMPARE_B) cmpBuf_nxt[1] = hwdata[15:0];
    if (wrPend_r && wrAddr_r == OFS_COMPARE_C) cmpBuf_nxt[2] = hwdata[15:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      waveCtrlA_r <= WAVE_CTRL_RST; // see RULE18
      ctrlB_r <= CTRL_B_RST;
      count_r <= CNT_BOTTOM;
      capTop_r <= CNT_BOTTOM;
      flags_r <= 5'h00;
      pinDir_r <= 3'h0;
      wave_r <= 3'h0;
      down_r <= 1'b0;
      hold_r <= 1'b0;
      pre_r <= 10'h000;
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      rdData_r <= 32'h0;
      for (int i = 0; i < 3; i++) begin
        cmpBuf_r[i] <= CNT_BOTTOM;
        cmpAct_r[i] <= CNT_BOTTOM;
      end
    end else begin
      waveCtrlA_r <= waveCtrlA_nxt;
      ctrlB_r <= ctrlB_nxt;
      count_r <= cntW;
      capTop_r <= capTop_nxt;
      flags_r <= flags_nxt;
      pinDir_r <= pinDir_nxt;
      wave_r <= wave_nxt;
      down_r <= down_nxt;
      hold_r <= hold_nxt;
      pre_r <= pre_nxt;
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      rdData_r <= rdData_nxt;
      for (int i = 0; i < 3; i++) begin
        cmpBuf_r[i] <= cmpBuf_nxt[i];
        cmpAct_r[i] <= cmpAct_nxt[i];
      end
    end
  end

  // ==========================================================
  // assertions
  a_top_reverse: assert property (@(posedge clk) disable iff (rst) // see RULE1
    tick && kind == KIND_DUAL && !down_r && atTop && !wrPend_r
    |=> down_r && hold_r) else $error("no reversal at top");
  a_top_hold: assert property (@(posedge clk) disable iff (rst) // see RULE2
    $rose(hold_r) && !$past(wrPend_r)
    |-> count_r == $past(count_r) - 16'h0001)
    else $error("top not held");
  a_cmp_flag: assert property (@(posedge clk) disable iff (rst) // see RULE3
    match[1] |=> flags_r[FLG_CMP_POS + 1]) else $error("flag missed");
  a_ovf_bottom: assert property (@(posedge clk) disable iff (rst) // see RULE4
    tick && kind == KIND_DUAL && atBottom && down_r
    |=> flags_r[FLG_OVF_POS] && cmpAct_r[1] == $past(cmpBuf_r[1]))
    else $error("overflow or reload missed");
  a_cap_top: assert property (@(posedge clk) disable iff (rst) // see RULE5
    tick && atTop && waveSel == WM_PFC_CAP |=> flags_r[FLG_CAP_POS])
    else $error("capture flag missed");
  a_buf_hold: assert property (@(posedge clk) disable iff (rst) // see RULE6
    kind == KIND_DUAL && !(tick && atBottom) |=> $stable(cmpAct_r[2]))
    else $error("compare loaded off bottom");
  a_dual_clear: assert property (@(posedge clk) disable iff (rst) // see RULE8
    kind == KIND_DUAL && match[1] && act[1] == ACT_CLEAR && !dirDown
    |=> !wave_r[1]) else $error("up match not cleared");
  a_handover: assert property (@(posedge clk) disable iff (rst) // see RULE14
    act[2] == ACT_OFF |-> pinOut[2] == portData[2])
    else $error("pin not at port");
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst) // see RULE22
    flags_r[FLG_OVF_POS] && !wrPend_r |=> flags_r[FLG_OVF_POS])
    else $error("flag dropped");
  c_dual_run: cover property (@(posedge clk) tick && atTop && down_nxt);
  c_bottom: cover property (@(posedge clk) tick && atBottom && down_r);
  c_toggle: cover property (@(posedge clk) match[0] && act[0] == ACT_TOGGLE);
endmodule // pfcpwm_top
`default_nettype wire

// >>> verification/pfcpwm_pin_load.sv
// partner model: external loads on the three waveform pins
`timescale 1ns/1ns
`default_nettype none
module pfcpwm_pin_load (
  input wire logic clk,
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe_n,
  output logic [2:0] portData,
  output logic [2:0] pinLevel
);
  // ============================================================
  // port pattern
  // changes every cycle so that a stale pass-through value shows up
  initial portData = 3'h5;
  always @(posedge clk) begin
    portData <= portData + 3'h3;
  end
  // ============================================================
  // pin level
  // an undriven pin floats to its pull-up level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinLevel[i] = pinOe_n[i] ? 1'b1 : pinOut[i];
    end
  end
endmodule // pfcpwm_pin_load
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: registers, waveforms and flags of the pwm timer block
`timescale 1ns/1ns
`default_nettype none
module tb_top import pfcpwm_pkg::*; ;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, portData, pinOut, pinOe_n, pinLevel;
  logic [31:0] hwdata, hrdata;
  int num_errors, checked;
  int divs[4] = '{8, 64, 256, 1024};
  assign hready = hreadyout;
  pfcpwm_top i_pfcpwm_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .portData(portData), .pinOut(pinOut), .pinOe_n(pinOe_n));
  pfcpwm_pin_load i_pfcpwm_pin_load (.clk(clk), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .portData(portData), .pinLevel(pinLevel));
  // ============================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #600000;
    num_errors++;
    stop_test();
  end
  // ============================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one single transfer; waits on hready are unbounded, the watchdog cuts a hang
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // high ticks in a window of two periods; dual slope unless fast mode
  function automatic int expHigh(logic [3:0] mode, int code, int t, int c,
      int dv);
    if (mode == WM_FAST_CAP) return 2 * (c + 1) * dv;
    if (code == 1) return 2 * t * dv;
    if (code == 2) return 4 * c * dv;
    return 4 * (t - c) * dv;
  endfunction
  task automatic runPwm(input logic [3:0] mode, input logic [1:0] codeA,
      input logic [1:0] codeB, input int t, input int c, input int dv,
      input logic [2:0] csel, input int pin);
    int per, highs;
    per = (mode == WM_FAST_CAP) ? (t + 1) * dv : 2 * t * dv;
    wr(OFS_CTRL_B, 32'h0);
    // normal mode copies buffers straight through, no stale top
    wr(OFS_WAVE_CTRL_A, 32'h0);
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_CAPTURE_TOP, 32'(t));
    wr(OFS_COMPARE_A, 32'(t));
    wr(OFS_COMPARE_B, 32'(c));
    wr(OFS_WAVE_CTRL_A, {24'h0, codeA, codeB, 2'h0, mode[1:0]});
    wr(OFS_CTRL_B, {27'h0, mode[3:2], csel});
    // settle first: new compares only land at bottom
    repeat (2 * per) @(posedge clk);
    highs = 0;
    repeat (2 * per) begin
      @(negedge clk);
      if (pinLevel[pin] === 1'b1) highs++;
    end
    check("pwm high ticks", 32'(highs),
      32'(expHigh(mode, codeA | codeB, t, c, dv)));
  endtask
  task automatic endTest(input string name);
    $display("test %s finished, mismatches so far %0d", name, num_errors);
  endtask
  // ============================================================
  // main sequence
  initial begin
    int r, t, c;
    logic [31:0] q;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    num_errors = 0;
    checked = 0;
    void'($urandom(20169));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4), q);
      check("reset value", q, 32'h0);
    end
    r = $urandom;
    wr(OFS_WAVE_CTRL_A, {24'h0, r[7:0]});
    rd(OFS_WAVE_CTRL_A, q);
    check("control a", q, {24'h0, r[7:0]});
    wr(OFS_CTRL_B, 32'h18);
    rd(OFS_CTRL_B, q);
    check("control b", q, 32'h18);
    wr(OFS_PIN_DIR, 32'h5);
    @(negedge clk);
    check("pin enables", {29'h0, pinOe_n}, 32'h2);
    wr(OFS_PIN_DIR, 32'h7);
    endTest("registers");
    // bottom, top and a middle compare, both polarities
    for (int k = 0; k < 6; k++) begin
      t = 4 + $urandom_range(16);
      c = (k % 3 == 0) ? 0 : (k % 3 == 1) ? t : $urandom_range(t - 1, 1);
      runPwm(WM_PFC_CAP, 2'h0, 2'(2 + k / 3), t, c, 1, 3'h1, 1);
    end
    @(negedge clk);
    check("pin a from port", 32'(pinOut[0]), 32'(portData[0]));
    rd(OFS_FLAGS, q);
    check("flags set", q & 32'h15, 32'h15);
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_FLAGS, 32'h1f);
    rd(OFS_FLAGS, q);
    check("flags cleared", q, 32'h0);
    endTest("dual slope");
    for (int k = 0; k < 4; k++) begin
      runPwm(WM_PFC_CAP, 2'h0, 2'h2, 4, 1, divs[k], 3'(k + 2), 1);
    end
    endTest("prescaler");
    t = 4 + $urandom_range(12);
    runPwm(WM_PFC_A, 2'h1, 2'h1, t, 2, 1, 3'h1, 0);
    @(negedge clk);
    check("pin b from port", 32'(pinOut[1]), 32'(portData[1]));
    endTest("toggle");
    t = 4 + $urandom_range(12);
    c = $urandom_range(t - 1, 1);
    runPwm(WM_FAST_CAP, 2'h0, 2'h2, t, c, 1, 3'h1, 1);
    endTest("fast pwm");
    // set first, then clear, so each code has to move the pin
    for (int code = 3; code >= 2; code--) begin
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_COMPARE_C, 32'h20);
      wr(OFS_COUNTER, 32'h10);
      wr(OFS_WAVE_CTRL_A, {24'h0, 4'h0, 2'(code), 2'h0});
      wr(OFS_CTRL_B, 32'h1);
      repeat (40) @(posedge clk);
      @(negedge clk);
      check("normal pin c", 32'(pinLevel[2]), 32'(code == 3));
    end
    endTest("normal mode");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
